// ---- common/ccpr_map.svh ----
// Constants for the class mode playback router.
// Assumes inclusion by the package and the design files by bare name.
// Overview of operation
// R1 - Direct mode sends each of 18 host channels to its own output only.
// R2 - Copy mode also duplicates host 1/2 onto phones 7/8 and digital pair 1/2.
// R3 - Copy mode sends host channels 3 to 8 to optical outputs 3 to 8.
// R4 - Mode switch allowed anytime; affects routing only, never mixer setup.
// R5 - Valid external digital input locks sample clock to external rate.
// R6 - No digital input present: run as clock master at host rate.
// R7 - Offer 18 inputs and 18 outputs to host at up to 96 kHz.
// R8 - Hold current configuration plus six stored setups with clock data.
// R9 - Encoder in setup menu toggles between setups 1 and 2 anytime.
// R10 - Remote buttons one to six recall setups 1 to 6 directly.
// R11 - Inputs pass channel processing to host; fader sets monitor to 1/2, 7/8. Code records in_data unprocessed.
// R12 - Width, mid/side and phase act on monitor path only.
// R13 - Playback passes output processing; output fader sets final level.
// R14 - Control room settings ignored; phones use output pair 7/8 settings.
// R15 - Gains outside supported set editable but without audible effect.
// R16 - Class mode active: encoder lists copy and direct entries too.
// R17 - Holding encoder on class entry toggles class mode, then reboot.
// R18 - Mode and setup changes take effect on a frame boundary.
`ifndef CCPR_MAP_SVH
`define CCPR_MAP_SVH
`define CCPR_NCH 18
`define CCPR_NSETUP 6
`define CCPR_MAX_RATE_KHZ 96
`define CCPR_CH_PH_L 6
`define CCPR_CH_PH_R 7
`define CCPR_CH_SPDIF_L 8
`define CCPR_CH_SPDIF_R 9
`define CCPR_CH_OPT1 10
`define CCPR_OPT_COUNT 8
// Short hold keeps a long-press test cheap; raise for a real panel
`define CCPR_HOLD_US 20
`define CCPR_CLK_MHZ 50
`define CCPR_HOLD_CYC (`CCPR_HOLD_US * `CCPR_CLK_MHZ)
`define CCPR_GAIN_RST 8'h00
`endif

// ---- common/ccpr_pkg.sv ----
// Types for the class mode playback router.
// Assumes the map header sits in the include path.
`include "ccpr_map.svh"
package ccpr_pkg;
  typedef logic [23:0] ccpr_sample_t;
  typedef ccpr_sample_t [`CCPR_NCH-1:0] ccpr_frame_t;
  typedef logic [7:0] ccpr_gain_t;
  typedef enum logic [1:0] {
    CCPR_ROUTE_DIRECT = 2'b01,
    CCPR_ROUTE_COPY = 2'b10
  } ccpr_route_e;
  typedef enum logic [3:0] {
    CCPR_MENU_CLASS = 4'b0001,
    CCPR_MENU_COPY = 4'b0010,
    CCPR_MENU_DIRECT = 4'b0100,
    CCPR_MENU_SETUP = 4'b1000
  } ccpr_menu_e;
  typedef struct packed {
    logic clock_master;
    logic [1:0] rate_sel;
    logic copy_mode;
    ccpr_gain_t [`CCPR_NCH-1:0] out_gain;
    logic [`CCPR_NCH-1:0] proc_en;
    logic [`CCPR_NCH-1:0] phase_inv;
  } ccpr_setup_s;
  typedef struct packed {
    ccpr_frame_t data;
    logic frame_start;
  } ccpr_beat_s;
endpackage

// ---- hdl/ccpr_router.sv ----
// Class mode playback router: routing, clock selection, setup recall, gains.
// Assumes one frame per in_valid beat and synchronous panel/remote pulses.
`timescale 1ns/10ps
`include "ccpr_map.svh"
module ccpr_router (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host playback frames
  input wire logic pb_valid,
  output logic pb_ready,
  input wire ccpr_pkg::ccpr_frame_t pb_data,
  // Physical output frames
  output logic out_valid,
  input wire logic out_ready,
  output ccpr_pkg::ccpr_frame_t out_data,
  // Physical input frames toward host and monitor
  input wire logic in_valid,
  input wire ccpr_pkg::ccpr_frame_t in_data,
  output logic rec_valid,
  output ccpr_pkg::ccpr_frame_t rec_data,
  output ccpr_pkg::ccpr_frame_t mon_data,
  input wire logic [`CCPR_NCH-1:0] mon_width_en,
  input wire ccpr_pkg::ccpr_gain_t [`CCPR_NCH-1:0] in_fader,
  // Clock selection
  input wire logic spdif_lock,
  input wire logic optical_lock,
  input wire logic [1:0] host_rate_sel,
  input wire logic [1:0] ext_rate_sel,
  output logic clock_master,
  output logic [1:0] active_rate_sel,
  // Setup memory
  input wire logic store_en,
  input wire logic [2:0] store_slot,
  input wire ccpr_pkg::ccpr_setup_s store_data,
  input wire logic [5:0] remote_btn,
  // Panel encoder
  input wire logic enc_turn,
  input wire logic enc_press,
  input wire logic enc_held,
  input wire logic [`CCPR_NCH-1:0] panel_gain_we,
  input wire ccpr_pkg::ccpr_gain_t panel_gain,
  input wire logic [`CCPR_NCH-1:0] ctrl_room_we,
  // Status
  output logic class_mode,
  output logic copy_mode,
  output ccpr_pkg::ccpr_menu_e menu_item,
  output logic [2:0] active_slot,
  output logic reboot_req,
  output logic class_on_show
);
  import ccpr_pkg::*;

  ccpr_setup_s slot_ff [`CCPR_NSETUP];
  ccpr_setup_s cur_ff;
  ccpr_gain_t [`CCPR_NCH-1:0] panel_gain_ff;
  logic class_ff;
  logic copy_ff;
  logic pend_copy_ff;
  logic pend_copy_vld_ff;
  logic [2:0] pend_slot_ff;
  logic pend_slot_vld_ff;
  logic [2:0] slot_ff_idx;
  ccpr_menu_e menu_ff;
  logic [31:0] hold_cnt_ff;
  logic hold_done_ff;
  logic reboot_ff;
  logic show_on_ff;
  ccpr_frame_t route;
  ccpr_frame_t rec_ff;
  ccpr_frame_t mon_ff;
  logic rec_vld_ff;
  logic frame_edge;
  logic [2:0] btn_slot;
  logic btn_any;

  assign frame_edge = pb_valid && pb_ready;

  // Setup store; current state survives stores to others
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CCPR_NSETUP; i++) slot_ff[i] <= '0;
    end else if (store_en && store_slot < 3'(`CCPR_NSETUP)) begin
      slot_ff[store_slot] <= store_data; // R8
    end
  end

  // Remote button decode, lowest button wins
  always_comb begin
    btn_slot = 3'd0;
    btn_any = 1'b0;
    for (int i = `CCPR_NSETUP - 1; i >= 0; i--) begin
      if (remote_btn[i]) begin
        btn_slot = 3'(i);
        btn_any = 1'b1;
      end
    end
  end

  // Pending recall requests, applied later at a frame edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_slot_ff <= 3'd0;
      pend_slot_vld_ff <= 1'b0;
    end else if (class_ff && btn_any) begin
      pend_slot_ff <= btn_slot; // R10
      pend_slot_vld_ff <= 1'b1;
    end else if (class_ff && menu_ff == CCPR_MENU_SETUP && enc_turn) begin
      pend_slot_ff <= (slot_ff_idx == 3'd0) ? 3'd1 : 3'd0; // R9
      pend_slot_vld_ff <= 1'b1;
    end else if (frame_edge) begin
      pend_slot_vld_ff <= 1'b0;
    end
  end

  // Current configuration; recall only on a frame edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      slot_ff_idx <= 3'd0;
    end else if (pend_slot_vld_ff && frame_edge) begin
      cur_ff <= slot_ff[pend_slot_ff]; // R18
      slot_ff_idx <= pend_slot_ff;
    end
  end

  // Routing mode; mixer state is never touched here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_copy_ff <= 1'b1;
      pend_copy_vld_ff <= 1'b0;
    end else if (class_ff && enc_press && menu_ff == CCPR_MENU_COPY) begin
      pend_copy_ff <= 1'b1; // R4
      pend_copy_vld_ff <= 1'b1;
    end else if (class_ff && enc_press && menu_ff == CCPR_MENU_DIRECT) begin
      pend_copy_ff <= 1'b0; // R4
      pend_copy_vld_ff <= 1'b1;
    end else if (frame_edge) begin
      pend_copy_vld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_ff <= 1'b1;
    end else if (pend_slot_vld_ff && frame_edge) begin
      copy_ff <= slot_ff[pend_slot_ff].copy_mode; // R18
    end else if (pend_copy_vld_ff && frame_edge) begin
      copy_ff <= pend_copy_ff; // R18
    end
  end

  // Menu walk; copy and direct entries exist only in class mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      menu_ff <= CCPR_MENU_SETUP;
    end else if (enc_turn) begin
      unique case (menu_ff)
        CCPR_MENU_SETUP: menu_ff <= CCPR_MENU_CLASS;
        CCPR_MENU_CLASS: menu_ff <= class_ff ? CCPR_MENU_COPY : CCPR_MENU_SETUP; // R16
        CCPR_MENU_COPY: menu_ff <= CCPR_MENU_DIRECT; // R16
        CCPR_MENU_DIRECT: menu_ff <= CCPR_MENU_SETUP;
        default: menu_ff <= CCPR_MENU_SETUP;
      endcase
    end
  end

  // Long hold on class entry toggles class mode and asks for reboot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_ff <= 32'd0;
      hold_done_ff <= 1'b0;
    end else if (enc_held && menu_ff == CCPR_MENU_CLASS) begin
      if (hold_cnt_ff != 32'(`CCPR_HOLD_CYC)) hold_cnt_ff <= hold_cnt_ff + 32'd1;
      hold_done_ff <= (hold_cnt_ff == 32'(`CCPR_HOLD_CYC) - 32'd1);
    end else begin
      hold_cnt_ff <= 32'd0;
      hold_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      class_ff <= 1'b0;
      show_on_ff <= 1'b0;
      reboot_ff <= 1'b0;
    end else begin
      reboot_ff <= hold_done_ff; // R17
      if (hold_done_ff) begin
        class_ff <= ~class_ff; // R17
        show_on_ff <= ~class_ff;
      end
    end
  end

  // Clock source: external lock wins, else host rate as master
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_master <= 1'b1;
      active_rate_sel <= 2'd0;
    end else if (spdif_lock || optical_lock) begin
      clock_master <= 1'b0; // R5
      active_rate_sel <= ext_rate_sel;
    end else begin
      clock_master <= 1'b1; // R6
      active_rate_sel <= host_rate_sel; // R7
    end
  end

  // Panel gains: stored always, never applied to any output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_gain_ff <= '{default: `CCPR_GAIN_RST};
    end else begin
      for (int i = 0; i < `CCPR_NCH; i++) begin
        if (panel_gain_we[i]) panel_gain_ff[i] <= panel_gain; // R15
      end
    end
  end

  // Playback routing and per-output processing
  always_comb begin
    route = pb_data; // R1
    if (copy_ff) begin
      route[`CCPR_CH_PH_L] = pb_data[0]; // R2
      route[`CCPR_CH_PH_R] = pb_data[1]; // R2
      route[`CCPR_CH_SPDIF_L] = pb_data[0]; // R2
      route[`CCPR_CH_SPDIF_R] = pb_data[1]; // R2
      route[`CCPR_CH_OPT1] = pb_data[0]; // R2
      route[`CCPR_CH_OPT1 + 1] = pb_data[1]; // R2
      for (int k = 2; k < `CCPR_OPT_COUNT; k++) begin
        route[`CCPR_CH_OPT1 + k] = pb_data[k]; // R3
      end
    end
  end

  // Output gain applies only to supported outputs; ctrl_room_we is ignored
  function automatic ccpr_sample_t scale(ccpr_sample_t s, ccpr_gain_t g, logic inv);
    logic [31:0] p;
    p = 32'($signed(s)) * 32'($signed({1'b0, g}));
    scale = inv ? ccpr_sample_t'(-(p >>> 7)) : ccpr_sample_t'(p >>> 7);
  endfunction

  ccpr_frame_t proc_out;
  genvar g;
  generate
    for (g = 0; g < `CCPR_NCH; g++) begin : gen_out
      logic heard;
      assign heard = (g < 2) || (g == `CCPR_CH_PH_L) || (g == `CCPR_CH_PH_R) ||
                     (g == `CCPR_CH_SPDIF_L) || (g == `CCPR_CH_SPDIF_R);
      assign proc_out[g] = cur_ff.proc_en[g] ?
          scale(route[g], heard ? cur_ff.out_gain[g] : 8'h80, 1'b0) : route[g]; // R13 R14 R15
    end
  endgenerate

  ccpr_skid u_skid (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(pb_valid),
    .in_ready(pb_ready),
    .in_data(proc_out),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // Record path carries unprocessed input; width and phase kept for monitor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_ff <= '0;
      rec_vld_ff <= 1'b0;
    end else begin
      rec_vld_ff <= in_valid;
      if (in_valid) begin
        for (int i = 0; i < `CCPR_NCH; i++) begin
          rec_ff[i] <= in_data[i]; // R11 R12
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_ff <= '0;
    end else if (in_valid) begin
      for (int i = 0; i < `CCPR_NCH; i++) begin
        mon_ff[i] <= scale(in_data[i], in_fader[i],
                           cur_ff.phase_inv[i] || mon_width_en[i]); // R11 R12
      end
    end
  end

  assign rec_valid = rec_vld_ff;
  assign rec_data = rec_ff;
  assign mon_data = mon_ff;
  assign class_mode = class_ff;
  assign copy_mode = copy_ff;
  assign menu_item = menu_ff;
  assign active_slot = slot_ff_idx;
  assign reboot_req = reboot_ff;
  assign class_on_show = show_on_ff;
endmodule

// ---- hdl/ccpr_skid.sv ----
// Two-entry buffer for whole sample frames on the output side.
// Assumes both sides share clk; ready on the drain side may stall freely.
`timescale 1ns/10ps
module ccpr_skid (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire ccpr_pkg::ccpr_frame_t in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output ccpr_pkg::ccpr_frame_t out_data
);
  import ccpr_pkg::*;
  ccpr_frame_t mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;
  assign in_ready = (count_ff != 2'd2);
  assign out_valid = (count_ff != 2'd0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- sim/ccpr_host_model.sv ----
// Host side model: plays frames into the router's playback port.
// Assumes the bench calls send from its main sequence.
`timescale 1ns/10ps
module ccpr_host_model (
  // Clock
  input wire logic clk,
  // Playback port
  output ccpr_pkg::ccpr_frame_t pb_data,
  output logic pb_valid,
  input wire logic pb_ready
);
  import ccpr_pkg::*;
  initial begin
    pb_valid = 1'b0;
    pb_data = '0;
  end
  // Holds an 18 channel frame until taken; gap makes a slow host
  task automatic send(input ccpr_frame_t f, input int gap);
    if (pb_valid) @(posedge clk); // Let the release of a prior frame land first
    repeat (gap) @(posedge clk);
    pb_valid <= 1'b1;
    pb_data <= f;
    do @(posedge clk); while (!pb_ready);
    pb_valid <= 1'b0;
    pb_data <= ~f; // Released data must not look valid
  endtask
endmodule

// ---- sim/ccpr_router_checker.sv ----
// Port assertions for the class mode playback router.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/10ps
module ccpr_router_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame ports
  input wire logic pb_valid,
  input wire logic pb_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire ccpr_pkg::ccpr_frame_t out_data,
  input wire logic in_valid,
  input wire logic rec_valid,
  // Clock selection
  input wire logic spdif_lock,
  input wire logic optical_lock,
  input wire logic [1:0] host_rate_sel,
  input wire logic [1:0] ext_rate_sel,
  input wire logic clock_master,
  input wire logic [1:0] active_rate_sel,
  // Status
  input wire logic copy_mode,
  input wire logic [2:0] active_slot
);
  import ccpr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mirror of buffer fill, so ready and valid are tied to real traffic
  logic [1:0] occ_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) occ_ff <= 2'h0;
    else occ_ff <= occ_ff + 2'(pb_valid && pb_ready) - 2'(out_valid && out_ready);
  end
  a_ready_room: assert property (pb_ready == (occ_ff != 2'h2))
    else $error("ready does not follow buffer room");
  a_valid_fill: assert property (out_valid == (occ_ff != 2'h0))
    else $error("valid does not follow buffer fill");
  a_hold_out: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled frame changed");
  a_take_answer: assert property (pb_valid && pb_ready |=> out_valid)
    else $error("taken frame not offered");
  a_rec_pulse: assert property (1'b1 |=> rec_valid == $past(in_valid))
    else $error("record pulse mismatch");
  a_ext_lock: assert property (spdif_lock || optical_lock |=>
    !clock_master && active_rate_sel == $past(ext_rate_sel))
    else $error("no lock to external rate");
  a_host_rate: assert property (!(spdif_lock || optical_lock) |=>
    clock_master && active_rate_sel == $past(host_rate_sel))
    else $error("not master at host rate");
  a_mode_frame: assert property ($changed(copy_mode) |-> $past(pb_valid && pb_ready))
    else $error("mode changed off a frame");
  a_slot_range: assert property (active_slot < 3'h6)
    else $error("slot out of range");
endmodule

// ---- sim/ccpr_router_tb.sv ----
// Bench for the class mode playback router: routing, recall, clock, buffer.
// Assumes the host model feeds playback; panel gain is tied, encoder turn and hold drive class entry.
`timescale 1ns/10ps
`include "ccpr_map.svh"
module ccpr_router_tb;
  import ccpr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pb_valid, pb_ready, out_valid, out_ready, in_valid, rec_valid, spdif_lock;
  logic optical_lock, clock_master, store_en, enc_turn, enc_press, enc_held;
  logic class_mode, copy_mode, reboot_req, class_on_show;
  ccpr_frame_t pb_data, out_data, in_data, rec_data, mon_data;
  logic [`CCPR_NCH-1:0] mon_width_en, panel_gain_we, ctrl_room_we;
  ccpr_gain_t [`CCPR_NCH-1:0] in_fader;
  logic [1:0] host_rate_sel, ext_rate_sel, active_rate_sel;
  logic [2:0] store_slot, active_slot;
  ccpr_setup_s store_data;
  logic [5:0] remote_btn;
  ccpr_gain_t panel_gain;
  ccpr_menu_e menu_item;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  ccpr_router uut (.clk, .rst_n, .pb_valid, .pb_ready, .pb_data, .out_valid, .out_ready,
    .out_data, .in_valid, .in_data, .rec_valid, .rec_data, .mon_data, .mon_width_en,
    .in_fader, .spdif_lock, .optical_lock, .host_rate_sel, .ext_rate_sel, .clock_master,
    .active_rate_sel, .store_en, .store_slot, .store_data, .remote_btn, .enc_turn,
    .enc_press, .enc_held, .panel_gain_we, .panel_gain, .ctrl_room_we, .class_mode,
    .copy_mode, .menu_item, .active_slot, .reboot_req, .class_on_show);
  ccpr_host_model host (.clk, .pb_data, .pb_valid, .pb_ready);
  function automatic ccpr_frame_t mk(input logic [7:0] b);
    for (int i = 0; i < `CCPR_NCH; i++) mk[i] = {b, 16'(i)};
  endfunction
  function automatic ccpr_frame_t route(input ccpr_frame_t f, input logic cp);
    route = f;
    if (cp) begin
      for (int i = 6; i < 12; i++) route[i] = f[i % 2];
      for (int i = 12; i < 18; i++) route[i] = f[i - 10];
    end
  endfunction
  task automatic chk(input string nm, input logic [431:0] exp, input logic [431:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic take(input ccpr_frame_t exp);
    int i = 0;
    do begin @(negedge clk); i++; end while (!out_valid && i < 20);
    chk("out_data", exp, out_data);
    @(posedge clk);
  endtask
  // Store a setup, recall it by remote button, then let one frame apply it
  task automatic recall(input int k, input logic cp);
    ccpr_setup_s s;
    s = '0;
    s.copy_mode = cp;
    s.out_gain = {`CCPR_NCH{8'h80}};
    @(posedge clk);
    store_en <= 1'b1;
    store_slot <= 3'(k);
    store_data <= s;
    @(posedge clk);
    store_en <= 1'b0;
    remote_btn <= 6'(1 << k);
    @(posedge clk);
    remote_btn <= 6'h0;
    host.send(mk(8'hee), 0);
    repeat (3) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      $display("[ERR] run exp done got timeout");
      end_of_test();
    end
  end
  initial begin
    {out_ready, in_valid, spdif_lock, optical_lock, store_en, enc_turn, enc_press} = '0;
    {enc_held, mon_width_en, panel_gain_we, in_fader, host_rate_sel, ext_rate_sel} = '0;
    {store_slot, store_data, remote_btn, panel_gain, in_data} = '0;
    ctrl_room_we = '1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("copy_mode", 1'b1, copy_mode);
    chk("pb_ready", 1'b1, pb_ready);
    // Enter class mode: turn to the class entry, then hold
    @(posedge clk) enc_turn <= 1'b1;
    @(posedge clk) enc_turn <= 1'b0;
    enc_held <= 1'b1;
    repeat (`CCPR_HOLD_CYC + 1) @(posedge clk);
    @(negedge clk);
    chk("reboot_req", 1'b1, reboot_req);
    chk("class_mode", 1'b1, class_mode);
    chk("class_on_show", 1'b1, class_on_show);
    @(posedge clk) enc_held <= 1'b0;
    @(posedge clk) out_ready <= 1'b1;
    for (int k = 0; k < `CCPR_NSETUP; k++) begin
      recall(k, k % 2 == 0);
      chk("copy_mode", k % 2 == 0, copy_mode);
      chk("active_slot", k, active_slot);
      host.send(mk(8'(k)), k);
      take(route(mk(8'(k)), k % 2 == 0));
    end
    @(posedge clk) out_ready <= 1'b0;
    host.send(mk(8'h10), 0);
    host.send(mk(8'h11), 0);
    @(negedge clk);
    chk("pb_ready", 1'b0, pb_ready);
    @(posedge clk) out_ready <= 1'b1;
    take(mk(8'h10));
    take(mk(8'h11));
    @(posedge clk);
    mon_width_en <= '1;
    in_fader <= {`CCPR_NCH{8'h80}};
    in_valid <= 1'b1;
    in_data <= mk(8'h5a);
    @(posedge clk) in_valid <= 1'b0;
    @(negedge clk);
    chk("rec_valid", 1'b1, rec_valid);
    chk("rec_data", mk(8'h5a), rec_data);
    for (int t = 0; t < 3; t++) begin
      @(posedge clk);
      {spdif_lock, optical_lock} <= 2'(t);
      ext_rate_sel <= 2'h2;
      host_rate_sel <= 2'(t + 1);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("clock_master", t == 0, clock_master);
      chk("active_rate_sel", t == 0 ? 1 : 2, active_rate_sel);
    end
    end_of_test();
  end
endmodule
bind ccpr_router ccpr_router_checker u_chk (.clk, .rst_n, .pb_valid, .pb_ready, .out_valid,
  .out_ready, .out_data, .in_valid, .rec_valid, .spdif_lock, .optical_lock, .host_rate_sel,
  .ext_rate_sel, .clock_master, .active_rate_sel, .copy_mode, .active_slot);
